// *** pkg/tpp_pkg.sv ***
package tpp_pkg;

    // ****************************************************************
    // Widths, reset values and encodings
    // ****************************************************************
    localparam int          DT_W          = 8;
    localparam logic [7:0]  DT_RESET      = 8'h00;
    localparam logic [2:0]  BUF_RESET     = 3'h0;
    localparam logic        SHAPE_RESET   = 1'b0;
    localparam logic        SHAPE_TRI     = 1'b0;
    localparam logic        SHAPE_SAW     = 1'b1;
    localparam logic        TRIG_OVF_ONLY = 1'b0;

    // ****************************************************************
    // Configuration, phase and state types
    // ****************************************************************
    typedef struct packed {
        logic mode_cfg_bit_zero;
        logic mode_cfg_bit_one;
        logic mode_cfg_bit_two;
        logic modulation_shape_select;
        logic phase_timer_trigger_select;
    } tpp_cfg_t;

    typedef struct packed {
        logic u;
        logic v;
        logic w;
    } tpp_phase_t;

    typedef enum logic [1:0] {
        TPP_IDLE = 2'b00,
        TPP_DEAD = 2'b01,
        TPP_ON   = 2'b11
    } tpp_dt_state_t;

endpackage

// *** hw/tpp_ctrl.sv ***
`timescale 1ns/1ps

// Overview of operation
// - Three-phase mode enables dead-time timer, phase output control and carrier interrupt circuit.
// - Triangular: dead-time timer starts on falling edge of its phase timer output.
// - Triangular: buffer copied to shift register once, on first trigger after a write.
// - Sawtooth: dead-time timer starts on phase falling edge and on transfer trigger.
// - Sawtooth: buffer copied to shift register on every transfer trigger.
// - Shape select zero means triangular, one means sawtooth; reset value zero.
// - Trigger select zero starts phase timers on carrier timer overflow only.
module tpp_ctrl
    import tpp_pkg::*;
(
    // Clock and reset.
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    // Configuration.
    input  wire tpp_cfg_t         i_cfg,
    input  wire logic [DT_W-1:0]  i_dead_time,
    // Buffer register write port.
    input  wire logic             i_buf_wr,
    input  wire tpp_phase_t       i_buf_data,
    // Timer events.
    input  wire logic             i_carrier_ovf,
    input  wire logic             i_carrier_wr,
    input  wire logic             i_xfer_trig,
    input  wire tpp_phase_t       i_phase_tmr,
    // Status and outputs.
    output logic                  o_phase_tmr_start,
    output logic                  o_carrier_int_en,
    output tpp_phase_t            o_shift,
    output tpp_phase_t            o_pos,
    output tpp_phase_t            o_neg
);

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    logic       mode_en;
    logic       saw;
    logic       xfer_ok;
    tpp_phase_t tmr_q;
    tpp_phase_t buf_q;
    logic       pend_q;
    tpp_phase_t shift_q;
    tpp_phase_t shift_d;

    assign mode_en = i_cfg.mode_cfg_bit_zero;
    assign saw     = (i_cfg.modulation_shape_select == SHAPE_SAW);
    assign xfer_ok = mode_en && i_xfer_trig;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_carrier_int_en <= 1'b0;
        end else begin
            o_carrier_int_en <= mode_en;
        end
    end

    // Phase timer start: overflow only, or also a write to the carrier timer.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_phase_tmr_start <= 1'b0;
        end else if (i_cfg.phase_timer_trigger_select == TRIG_OVF_ONLY) begin
            o_phase_tmr_start <= mode_en && i_carrier_ovf;
        end else begin
            o_phase_tmr_start <= mode_en && (i_carrier_ovf || i_carrier_wr);
        end
    end

    // ****************************************************************
    // Buffer and shift register
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            buf_q <= BUF_RESET;
        end else if (i_buf_wr) begin
            buf_q <= i_buf_data;
        end
    end

    // A write landing with a trigger keeps the request pending so it is not lost.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pend_q <= 1'b0;
        end else if (i_buf_wr) begin
            pend_q <= 1'b1;
        end else if (xfer_ok) begin
            pend_q <= 1'b0;
        end
    end

    // Dead-time starts latch this next value, so a transfer and a start in one cycle use the new data.
    assign shift_d = (xfer_ok && (saw || pend_q)) ? buf_q : shift_q;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            shift_q <= BUF_RESET;
        end else begin
            shift_q <= shift_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_shift <= BUF_RESET;
        end else begin
            o_shift <= shift_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tmr_q <= BUF_RESET;
        end else begin
            tmr_q <= i_phase_tmr;
        end
    end

    // ****************************************************************
    // Dead-time per phase
    // ****************************************************************
    // Outputs follow the shift register level latched at start; both are off from one cycle after counting starts until one cycle after it ends.
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ph
            tpp_dt_state_t   st_q;
            logic [DT_W-1:0] cnt_q;
            logic            lvl_q;
            logic            start;
            logic            fall;

            assign fall  = tmr_q[2-g] && !i_phase_tmr[2-g];
            assign start = mode_en && (fall || (saw && i_xfer_trig));

            always_ff @(posedge i_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    st_q  <= TPP_IDLE;
                    cnt_q <= DT_RESET;
                    lvl_q <= 1'b0;
                end else if (!mode_en) begin
                    st_q  <= TPP_IDLE;
                    cnt_q <= DT_RESET;
                end else if (start) begin
                    st_q  <= TPP_DEAD;
                    cnt_q <= i_dead_time;
                    lvl_q <= shift_d[2-g];
                end else begin
                    unique case (st_q)
                        TPP_IDLE: begin
                            st_q <= TPP_IDLE;
                        end
                        TPP_DEAD: begin
                            if (cnt_q == DT_RESET) begin
                                st_q <= TPP_ON;
                            end else begin
                                cnt_q <= cnt_q - 8'h01;
                            end
                        end
                        TPP_ON: begin
                            st_q <= TPP_ON;
                        end
                        default: begin
                            st_q <= TPP_IDLE;
                        end
                    endcase
                end
            end

            always_ff @(posedge i_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    o_pos[2-g] <= 1'b0;
                    o_neg[2-g] <= 1'b0;
                end else begin
                    o_pos[2-g] <= (st_q == TPP_ON) && lvl_q;
                    o_neg[2-g] <= (st_q == TPP_ON) && !lvl_q;
                end
            end

            dead_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
                start |=> ##1 (!o_pos[2-g] && !o_neg[2-g]))
                else $error("Phase output active during dead time.");
        end
    endgenerate

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_write_then_trig;
        i_buf_wr ##1 (xfer_ok && !i_buf_wr);
    endsequence

    tri_once_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (xfer_ok && !saw && !pend_q) |=> (shift_q == $past(shift_q)))
        else $error("Triangular transfer without a pending write.");

    tri_copy_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_write_then_trig |=> (shift_q == $past(buf_q)))
        else $error("Buffer not copied after write.");

    saw_copy_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (xfer_ok && saw) |=> (shift_q == $past(buf_q)))
        else $error("Sawtooth transfer missed.");

    mode_int_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        mode_en |=> o_carrier_int_en)
        else $error("Carrier interrupt circuit not enabled.");

    ovf_start_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (mode_en && !i_cfg.phase_timer_trigger_select && i_carrier_wr && !i_carrier_ovf)
        |=> !o_phase_tmr_start)
        else $error("Phase timers started without overflow.");

    off_mode_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !mode_en [*3] |-> (o_pos == BUF_RESET && o_neg == BUF_RESET))
        else $error("Phase outputs active outside three-phase mode.");

    no_overlap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (o_pos & o_neg) == BUF_RESET)
        else $error("Both complementary outputs active.");

endmodule

// *** verification/tpp_gate_drv.sv ***
`timescale 1ns/1ps

// ****************************************
// Inverter gate driver model
// ****************************************
// A leg with both switches on shorts the bus, so that is latched as a fault.
module tpp_gate_drv
    import tpp_pkg::*;
(
    // Clock and reset.
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    // Gate commands.
    input  wire tpp_phase_t i_pos,
    input  wire tpp_phase_t i_neg,
    // Fault report.
    output logic            o_fault
);
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_fault <= 1'b0;
        end else if ((i_pos & i_neg) != 3'h0) begin
            o_fault <= 1'b1;
        end
    end
endmodule

// *** verification/three_phase_pwm_transfer_control_tb.sv ***
`timescale 1ns/1ps

// ****************************************
// Bench
// ****************************************
module three_phase_pwm_transfer_control_tb
    import tpp_pkg::*;
;
    localparam logic [7:0] DT = 8'h04;
    logic       i_clk, i_nrst, i_buf_wr, i_carrier_ovf, i_carrier_wr, i_xfer_trig;
    tpp_cfg_t   i_cfg;
    tpp_phase_t i_buf_data, i_phase_tmr, o_shift, o_pos, o_neg;
    logic       o_phase_tmr_start, o_carrier_int_en, fault;
    int         n_fail, comparisons;

    tpp_ctrl u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_cfg(i_cfg), .i_dead_time(DT),
        .i_buf_wr(i_buf_wr), .i_buf_data(i_buf_data), .i_carrier_ovf(i_carrier_ovf),
        .i_carrier_wr(i_carrier_wr), .i_xfer_trig(i_xfer_trig), .i_phase_tmr(i_phase_tmr),
        .o_phase_tmr_start(o_phase_tmr_start), .o_carrier_int_en(o_carrier_int_en),
        .o_shift(o_shift), .o_pos(o_pos), .o_neg(o_neg));
    tpp_gate_drv u_drv (.i_clk(i_clk), .i_nrst(i_nrst), .i_pos(o_pos), .i_neg(o_neg), .o_fault(fault));

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic wr(input logic [2:0] d, input logic t);
        i_buf_data = d;
        i_buf_wr = 1'b1;
        i_xfer_trig = t;
        cyc(1);
        i_buf_wr = 1'b0;
        if (t) begin
            i_xfer_trig = 1'b0;
        end
    endtask
    task automatic stop_test();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // The carrier counter is written before mode bit one is set.
    task automatic t_mode();
        chk(o_carrier_int_en, 1'b0);
        i_carrier_wr = 1'b1;
        cyc(1);
        i_carrier_wr = 1'b0;
        i_cfg.mode_cfg_bit_zero = 1'b1;
        i_cfg.mode_cfg_bit_one = 1'b1;
        cyc(2);
        chk(o_carrier_int_en, 1'b1);
        i_carrier_wr = 1'b1;
        cyc(1);
        i_carrier_wr = 1'b0;
        chk(o_phase_tmr_start, 1'b0);
        i_carrier_ovf = 1'b1;
        cyc(1);
        i_carrier_ovf = 1'b0;
        chk(o_phase_tmr_start, 1'b1);
        cyc(1);
        chk(o_phase_tmr_start, 1'b0);
        i_cfg.phase_timer_trigger_select = 1'b1;
        i_carrier_wr = 1'b1;
        cyc(1);
        i_carrier_wr = 1'b0;
        chk(o_phase_tmr_start, 1'b1);
        i_cfg.phase_timer_trigger_select = TRIG_OVF_ONLY;
        cyc(1);
        chk(o_phase_tmr_start, 1'b0);
        $display("test mode done");
    endtask

    task automatic t_tri();
        wr(3'h5, 1'b0);
        cyc(2);
        chk(o_shift, 3'h0);
        i_xfer_trig = 1'b1;
        cyc(1);
        i_xfer_trig = 1'b0;
        cyc(1);
        chk(o_shift, 3'h5);
        wr(3'h2, 1'b1);
        cyc(1);
        chk(o_shift, 3'h5);
        wr(3'h2, 1'b0);
        i_xfer_trig = 1'b1;
        cyc(1);
        i_xfer_trig = 1'b0;
        cyc(1);
        chk(o_shift, 3'h2);
        $display("test triangular done");
    endtask

    // Output turns on dead time plus two edges after the edge that sees the fall.
    task automatic t_dead();
        i_phase_tmr = 3'h5;
        cyc(DT + 2);
        chk({o_pos[1], o_neg[1]}, 2'h0);
        cyc(1);
        chk({o_pos[1], o_neg[1]}, 2'h2);
        i_phase_tmr = 3'h4;
        cyc(DT + 2);
        chk({o_pos[0], o_neg[0]}, 2'h0);
        chk(o_pos[1], 1'b1);
        cyc(1);
        chk({o_pos[0], o_neg[0]}, 2'h1);
        chk(fault, 1'b0);
        $display("test dead time done");
    endtask

    // Shape is changed here while no timer runs.
    task automatic t_saw();
        i_cfg.modulation_shape_select = SHAPE_SAW;
        wr(3'h3, 1'b0);
        i_xfer_trig = 1'b1;
        cyc(1);
        i_xfer_trig = 1'b0;
        cyc(1);
        chk(o_shift, 3'h3);
        cyc(1);
        chk(o_pos, 3'h0);
        chk(o_neg, 3'h0);
        cyc(4);
        chk(o_pos, 3'h3);
        chk(o_neg, 3'h4);
        chk(fault, 1'b0);
        i_cfg.mode_cfg_bit_zero = 1'b0;
        cyc(3);
        chk(o_pos | o_neg, 3'h0);
        $display("test sawtooth done");
    endtask

    initial begin
        i_nrst = 1'b0;
        i_cfg = '0;
        i_buf_wr = 1'b0;
        i_buf_data = 3'h0;
        i_carrier_ovf = 1'b0;
        i_carrier_wr = 1'b0;
        i_xfer_trig = 1'b0;
        i_phase_tmr = 3'h7;
        n_fail = 0;
        comparisons = 0;
        cyc(6);
        i_nrst = 1'b1;
        cyc(1);
        t_mode();
        t_tri();
        t_dead();
        t_saw();
        stop_test();
    end

    initial begin
        #(25 * 2000);
        n_fail++;
        stop_test();
    end
endmodule
